/* File: hdl/seq_p2_pkg.sv */
// Constants and types for the second product term of one sequencer output.
// Assumes a single clock domain and word-wide AHB-Lite register access.
//
// What this block does
// - Primary threshold bits select voltage inputs one-six
// - Bits six, seven select watchdog one, two
// - Secondary threshold bits select voltage inputs one-six
// - Bits six, seven select general inputs one, two
// - Bits zero, one select general inputs three, four
// - Bits two, three select outputs one, two
// - Bits four-seven select outputs four-seven
// - Bit one selects output eight
// - Manual reset select forces assertion while low
// - A cleared select bit ignores its signal
// - Output deasserts when either product is one and manual reset is not forcing it
// - Logic drives output three of large variant
// - Product is one only when all selected good
`default_nettype none

package seq_p2_pkg;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_P2_PRIMARY = 8'h19;
    localparam logic [7:0] IDX_P2_SECONDARY = 8'h1a;
    localparam logic [7:0] IDX_P2_OUTPUTS = 8'h1b;
    localparam logic [7:0] IDX_OUT8_SELECT = 8'h1c;
    localparam logic [7:0] IDX_MANUAL_SELECT = 8'h40;
    localparam logic [7:0] IDX_STATUS = 8'h41;

    localparam logic [9:0] ADDR_P2_PRIMARY = {IDX_P2_PRIMARY, 2'b00};
    localparam logic [9:0] ADDR_P2_SECONDARY = {IDX_P2_SECONDARY, 2'b00};
    localparam logic [9:0] ADDR_P2_OUTPUTS = {IDX_P2_OUTPUTS, 2'b00};
    localparam logic [9:0] ADDR_OUT8_SELECT = {IDX_OUT8_SELECT, 2'b00};
    localparam logic [9:0] ADDR_MANUAL_SELECT = {IDX_MANUAL_SELECT, 2'b00};
    localparam logic [9:0] ADDR_STATUS = {IDX_STATUS, 2'b00};

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int OUT8_SEL_BIT = 1;
    localparam int MANUAL_SEL_BIT = 2;
    localparam int STAT_PRODUCT2_BIT = 0;
    localparam int STAT_TARGET_BIT = 1;
    localparam int STAT_PRODUCT1_BIT = 2;
    localparam int STAT_MANUAL_BIT = 3;

    // Flattened select vector: three full bytes, then the output-eight bit
    localparam int SEL_WIDTH = 25;
    localparam int SEL_BASE_PRIMARY = 0;
    localparam int SEL_BASE_SECONDARY = 8;
    localparam int SEL_BASE_OUTPUTS = 16;
    localparam int SEL_POS_OUT8 = 24;

    // ------------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_P2_PRIMARY = 8'h00;
    localparam logic [7:0] RST_P2_SECONDARY = 8'h00;
    localparam logic [7:0] RST_P2_OUTPUTS = 8'h00;
    localparam logic [7:0] RST_OUT8_SELECT = 8'h00;
    localparam logic [7:0] RST_MANUAL_SELECT = 8'h00;
    localparam logic [1:0] RST_SYNC = 2'h0;

    // ------------------------------------------------------------------
    // Bus constants
    // ------------------------------------------------------------------
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic HRESP_OKAY = 1'h0;

    typedef enum logic [1:0] {
        PHASE_IDLE = 2'b00,
        PHASE_WRITE = 2'b01,
        PHASE_READ = 2'b10
    } bus_phase_type;

endpackage

`default_nettype wire

/* File: hdl/product_term_eval.sv */
// Product term evaluator: AND of every selected good condition, zero when none is selected.
// Assumes select and good vectors share the packed bit order of the package.
`default_nettype none

module product_term_eval (
    input wire logic [seq_p2_pkg::SEL_WIDTH-1:0] sel,
    input wire logic [seq_p2_pkg::SEL_WIDTH-1:0] good,
    output logic term
);

    logic [seq_p2_pkg::SEL_WIDTH-1:0] miss;

    // ------------------------------------------------------------------
    // Per-condition miss
    // ------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < seq_p2_pkg::SEL_WIDTH; i = i + 1) begin : g_miss
            // Unselected bit can never spoil the term
            assign miss[i] = sel[i] & ~good[i];
        end
    endgenerate

    // Empty selection gives zero, so an unprogrammed term never deasserts
    assign term = (|sel) & ~(|miss);

endmodule

`default_nettype wire

/* File: hdl/seq_output_product2_dependency.sv */
// Top of the product-2 dependency logic for one sequencer output,
// with its select registers on an AHB-Lite slave.
// Assumes all inputs synchronous to REF_CLK and one slave on the bus.
`default_nettype none

module seq_output_product2_dependency (
    input wire logic REF_CLK,
    input wire logic RSTN,
    input wire logic CLK_EN,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic HREADYOUT,
    output logic [31:0] HRDATA,
    output logic HRESP,
    input wire logic [5:0] VOLT_PRIMARY_GOOD,
    input wire logic [5:0] VOLT_SECONDARY_GOOD,
    input wire logic [1:0] WATCHDOG_EXPIRED,
    input wire logic [3:0] GENERAL_INPUT_ACTIVE,
    input wire logic PROG_OUTPUT_ONE,
    input wire logic PROG_OUTPUT_TWO,
    input wire logic PROG_OUTPUT_FOUR,
    input wire logic PROG_OUTPUT_FIVE,
    input wire logic PROG_OUTPUT_SIX,
    input wire logic PROG_OUTPUT_SEVEN,
    input wire logic PROG_OUTPUT_EIGHT,
    input wire logic MANUAL_RESET_N,
    input wire logic PRODUCT1_TERM,
    output logic PRODUCT2_TERM,
    output logic TARGET_OUTPUT
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        seq_p2_pkg::bus_phase_type phase;
        logic [7:0] wr_index;
        logic [31:0] rdata;
        logic [7:0] p2_voltage_primary_and_watchdog_select;
        logic [7:0] p2_voltage_secondary_and_gpin_select;
        logic [7:0] p2_gpin_and_output_select;
        logic [7:0] output_eight_dependency_select;
        logic [7:0] manual_reset_assert_select;
        logic product1_seen;
        logic manual_force;
        logic product2;
        logic target_output;
    } state_type;

    localparam state_type STATE_RESET = '{
        phase: seq_p2_pkg::PHASE_IDLE,
        wr_index: 8'h00,
        rdata: 32'h0000_0000,
        p2_voltage_primary_and_watchdog_select: seq_p2_pkg::RST_P2_PRIMARY,
        p2_voltage_secondary_and_gpin_select: seq_p2_pkg::RST_P2_SECONDARY,
        p2_gpin_and_output_select: seq_p2_pkg::RST_P2_OUTPUTS,
        output_eight_dependency_select: seq_p2_pkg::RST_OUT8_SELECT,
        manual_reset_assert_select: seq_p2_pkg::RST_MANUAL_SELECT,
        product1_seen: 1'b0,
        manual_force: 1'b0,
        product2: 1'b0,
        // Asserted until the terms are first evaluated: safe default
        target_output: 1'b1
    };

    state_type state_reg;
    state_type state_next;
    logic [1:0] rst_sync_reg;
    logic rst_n;
    logic [seq_p2_pkg::SEL_WIDTH-1:0] sel_vec;
    logic [seq_p2_pkg::SEL_WIDTH-1:0] good_vec;
    logic p2_comb;
    logic addr_valid;
    logic lane_ok;
    logic [7:0] addr_index;

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_sync_reg <= seq_p2_pkg::RST_SYNC;
        end else if (CLK_EN) begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_reg[1];

    // ------------------------------------------------------------------
    // Condition vectors
    // ------------------------------------------------------------------
    assign sel_vec = {
        state_reg.output_eight_dependency_select[seq_p2_pkg::OUT8_SEL_BIT],
        state_reg.p2_gpin_and_output_select,
        state_reg.p2_voltage_secondary_and_gpin_select,
        state_reg.p2_voltage_primary_and_watchdog_select
    };

    // A selected output counts as good while it is deasserted
    assign good_vec = {
        ~PROG_OUTPUT_EIGHT,
        ~PROG_OUTPUT_SEVEN,
        ~PROG_OUTPUT_SIX,
        ~PROG_OUTPUT_FIVE,
        ~PROG_OUTPUT_FOUR,
        ~PROG_OUTPUT_TWO,
        ~PROG_OUTPUT_ONE,
        ~GENERAL_INPUT_ACTIVE[3:2],
        ~GENERAL_INPUT_ACTIVE[1:0],
        VOLT_SECONDARY_GOOD,
        ~WATCHDOG_EXPIRED,
        VOLT_PRIMARY_GOOD
    };

    product_term_eval u_term (
        .sel(sel_vec),
        .good(good_vec),
        .term(p2_comb)
    );

    // ------------------------------------------------------------------
    // Register read mux
    // ------------------------------------------------------------------
    function automatic logic [31:0] read_word(input logic [7:0] idx, input state_type s);
        logic [31:0] w;
        w = 32'h0000_0000;
        case (idx)
            seq_p2_pkg::IDX_P2_PRIMARY: begin
                w[7:0] = s.p2_voltage_primary_and_watchdog_select;
            end
            seq_p2_pkg::IDX_P2_SECONDARY: begin
                w[7:0] = s.p2_voltage_secondary_and_gpin_select;
            end
            seq_p2_pkg::IDX_P2_OUTPUTS: begin
                w[7:0] = s.p2_gpin_and_output_select;
            end
            seq_p2_pkg::IDX_OUT8_SELECT: begin
                w[7:0] = s.output_eight_dependency_select;
            end
            seq_p2_pkg::IDX_MANUAL_SELECT: begin
                w[7:0] = s.manual_reset_assert_select;
            end
            seq_p2_pkg::IDX_STATUS: begin
                w[seq_p2_pkg::STAT_PRODUCT2_BIT] = s.product2;
                w[seq_p2_pkg::STAT_TARGET_BIT] = s.target_output;
                w[seq_p2_pkg::STAT_PRODUCT1_BIT] = s.product1_seen;
                w[seq_p2_pkg::STAT_MANUAL_BIT] = s.manual_force;
            end
            default: begin
                w = 32'h0000_0000;
            end
        endcase
        return w;
    endfunction

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // Upper address bits alias: the slave decodes a 1 KB window only
    assign addr_index = HADDR[9:2];
    assign addr_valid = HSEL & HTRANS[1] & HREADY;
    // Only byte lane zero carries data; other lanes are ignored
    assign lane_ok = (HADDR[1:0] == 2'b00) && (HSIZE <= seq_p2_pkg::HSIZE_WORD);

    always_comb begin
        state_next = state_reg;
        if (state_reg.phase == seq_p2_pkg::PHASE_WRITE) begin
            case (state_reg.wr_index)
                seq_p2_pkg::IDX_P2_PRIMARY: begin
                    state_next.p2_voltage_primary_and_watchdog_select = HWDATA[7:0];
                end
                seq_p2_pkg::IDX_P2_SECONDARY: begin
                    state_next.p2_voltage_secondary_and_gpin_select = HWDATA[7:0];
                end
                seq_p2_pkg::IDX_P2_OUTPUTS: begin
                    state_next.p2_gpin_and_output_select = HWDATA[7:0];
                end
                seq_p2_pkg::IDX_OUT8_SELECT: begin
                    state_next.output_eight_dependency_select = HWDATA[7:0];
                end
                seq_p2_pkg::IDX_MANUAL_SELECT: begin
                    state_next.manual_reset_assert_select = HWDATA[7:0];
                end
                default: begin
                    state_next.wr_index = state_reg.wr_index;
                end
            endcase
        end
        state_next.phase = seq_p2_pkg::PHASE_IDLE;
        state_next.rdata = 32'h0000_0000;
        if (addr_valid && HWRITE && lane_ok) begin
            state_next.phase = seq_p2_pkg::PHASE_WRITE;
            state_next.wr_index = addr_index;
        end else if (addr_valid && !HWRITE) begin
            state_next.phase = seq_p2_pkg::PHASE_READ;
            // Read after the pending write, so back-to-back readback is fresh
            state_next.rdata = read_word(addr_index, state_next);
        end
        state_next.product1_seen = PRODUCT1_TERM;
        state_next.product2 = p2_comb;
        state_next.manual_force =
            state_reg.manual_reset_assert_select[seq_p2_pkg::MANUAL_SEL_BIT] &
            ~MANUAL_RESET_N;
        // Manual reset wins over the deassert terms
        state_next.target_output = ~(PRODUCT1_TERM | p2_comb) |
            state_next.manual_force;
    end

    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= STATE_RESET;
        end else if (CLK_EN) begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Zero wait states: every transfer completes in its first data cycle
    assign HREADYOUT = 1'b1;
    assign HRESP = seq_p2_pkg::HRESP_OKAY;
    assign HRDATA = state_reg.rdata;
    assign PRODUCT2_TERM = state_reg.product2;
    assign TARGET_OUTPUT = state_reg.target_output;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!rst_n);

    logic [7:0] prim_sel;
    logic [7:0] sec_sel;
    logic [7:0] out_sel;
    logic all_good;
    assign prim_sel = state_reg.p2_voltage_primary_and_watchdog_select;
    assign sec_sel = state_reg.p2_voltage_secondary_and_gpin_select;
    assign out_sel = state_reg.p2_gpin_and_output_select;
    assign all_good = ((sel_vec & ~good_vec) == {seq_p2_pkg::SEL_WIDTH{1'b0}});

    property p_primary_fail;
        CLK_EN && prim_sel[0] && !VOLT_PRIMARY_GOOD[0] |=> !PRODUCT2_TERM;
    endproperty
    a_primary_fail: assert property (p_primary_fail)
        else $error("primary threshold failure did not clear product two");

    property p_watchdog_fail;
        CLK_EN && prim_sel[7] && WATCHDOG_EXPIRED[1] |=> !PRODUCT2_TERM;
    endproperty
    a_watchdog_fail: assert property (p_watchdog_fail)
        else $error("expired watchdog two did not clear product two");

    property p_secondary_fail;
        CLK_EN && sec_sel[5] && !VOLT_SECONDARY_GOOD[5] |=> !PRODUCT2_TERM;
    endproperty
    a_secondary_fail: assert property (p_secondary_fail)
        else $error("secondary threshold failure did not clear product two");

    property p_gpin_low_fail;
        CLK_EN && sec_sel[6] && GENERAL_INPUT_ACTIVE[0] |=> !PRODUCT2_TERM;
    endproperty
    a_gpin_low_fail: assert property (p_gpin_low_fail)
        else $error("active general input one did not clear product two");

    property p_gpin_high_fail;
        CLK_EN && out_sel[1] && GENERAL_INPUT_ACTIVE[3] |=> !PRODUCT2_TERM;
    endproperty
    a_gpin_high_fail: assert property (p_gpin_high_fail)
        else $error("active general input four did not clear product two");

    property p_out_two_fail;
        CLK_EN && out_sel[3] && PROG_OUTPUT_TWO |=> !PRODUCT2_TERM;
    endproperty
    a_out_two_fail: assert property (p_out_two_fail)
        else $error("asserted output two did not clear product two");

    property p_out_four_fail;
        CLK_EN && out_sel[4] && PROG_OUTPUT_FOUR |=> !PRODUCT2_TERM;
    endproperty
    a_out_four_fail: assert property (p_out_four_fail)
        else $error("asserted output four did not clear product two");

    property p_out_eight_fail;
        CLK_EN && state_reg.output_eight_dependency_select[seq_p2_pkg::OUT8_SEL_BIT] &&
            PROG_OUTPUT_EIGHT |=> !PRODUCT2_TERM;
    endproperty
    a_out_eight_fail: assert property (p_out_eight_fail)
        else $error("asserted output eight did not clear product two");

    property p_manual_force;
        CLK_EN && state_reg.manual_reset_assert_select[seq_p2_pkg::MANUAL_SEL_BIT] &&
            !MANUAL_RESET_N |=> TARGET_OUTPUT;
    endproperty
    a_manual_force: assert property (p_manual_force)
        else $error("manual reset low did not assert the output");

    property p_empty_select;
        CLK_EN && (sel_vec == {seq_p2_pkg::SEL_WIDTH{1'b0}}) |=> !PRODUCT2_TERM;
    endproperty
    a_empty_select: assert property (p_empty_select)
        else $error("product two set with no condition selected");

    property p_deassert;
        CLK_EN |=> TARGET_OUTPUT == (!($past(PRODUCT1_TERM) || PRODUCT2_TERM) ||
            state_reg.manual_force);
    endproperty
    a_deassert: assert property (p_deassert)
        else $error("output level does not follow the two product terms");

    property p_all_good;
        CLK_EN && (sel_vec != {seq_p2_pkg::SEL_WIDTH{1'b0}}) && all_good |=> PRODUCT2_TERM;
    endproperty
    a_all_good: assert property (p_all_good)
        else $error("product two clear although every selected condition is good");

    property p_write_takes;
        CLK_EN && addr_valid && HWRITE && lane_ok &&
            (addr_index == seq_p2_pkg::IDX_P2_OUTPUTS) ##1 CLK_EN |=>
            out_sel == $past(HWDATA[7:0]);
    endproperty
    a_write_takes: assert property (p_write_takes)
        else $error("bus write did not reach the output select register");

    c_p2_deasserts: cover property (CLK_EN && PRODUCT2_TERM && !TARGET_OUTPUT);
    c_manual: cover property (CLK_EN && state_reg.manual_force && TARGET_OUTPUT);
    c_multi: cover property (CLK_EN && prim_sel[0] && sec_sel[7] && out_sel[7] && all_good);
    c_read: cover property (state_reg.phase == seq_p2_pkg::PHASE_READ && HRDATA != 32'h0);
    c_frozen: cover property (!CLK_EN && state_reg.product2);

endmodule

`default_nettype wire

/* File: tb/seq_output_product2_dependency_test.sv */
// Self-checking bench for the product-2 dependency block and its register slave.
// Assumes zero or more AHB-Lite wait states and one clock; CLK_EN high but in one freeze test.
`default_nettype none

module seq_output_product2_dependency_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic REF_CLK = 1'b0;
    logic RSTN = 1'b0;
    logic CLK_EN = 1'b1;
    logic HSEL = 1'b0;
    logic HWRITE = 1'b0;
    logic [31:0] HADDR = 32'h0;
    logic [31:0] HWDATA = 32'h0;
    logic [1:0] HTRANS = 2'h0;
    logic [2:0] HSIZE = 3'h0;
    logic [5:0] VOLT_PRIMARY_GOOD = 6'h3f;
    logic [5:0] VOLT_SECONDARY_GOOD = 6'h3f;
    logic [1:0] WATCHDOG_EXPIRED = 2'h0;
    logic [3:0] GENERAL_INPUT_ACTIVE = 4'h0;
    logic [6:0] prog_bad = 7'h0;
    logic MANUAL_RESET_N = 1'b1;
    logic PRODUCT1_TERM = 1'b0;
    logic HREADYOUT;
    logic HRESP;
    logic PRODUCT2_TERM;
    logic TARGET_OUTPUT;
    logic [31:0] HRDATA;
    int bad_count = 0;
    int total_checks = 0;
    logic [7:0] mreg [5];
    logic [9:0] maddr [5];
    logic [31:0] rdat;
    logic [31:0] rnd;
    logic [24:0] s;
    logic [24:0] bad;

    seq_output_product2_dependency i_dut (
        .REF_CLK(REF_CLK), .RSTN(RSTN), .CLK_EN(CLK_EN), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
        .HREADY(HREADYOUT), .HREADYOUT(HREADYOUT), .HRDATA(HRDATA), .HRESP(HRESP),
        .VOLT_PRIMARY_GOOD(VOLT_PRIMARY_GOOD), .VOLT_SECONDARY_GOOD(VOLT_SECONDARY_GOOD),
        .WATCHDOG_EXPIRED(WATCHDOG_EXPIRED), .GENERAL_INPUT_ACTIVE(GENERAL_INPUT_ACTIVE),
        .PROG_OUTPUT_ONE(prog_bad[0]), .PROG_OUTPUT_TWO(prog_bad[1]),
        .PROG_OUTPUT_FOUR(prog_bad[2]), .PROG_OUTPUT_FIVE(prog_bad[3]),
        .PROG_OUTPUT_SIX(prog_bad[4]), .PROG_OUTPUT_SEVEN(prog_bad[5]),
        .PROG_OUTPUT_EIGHT(prog_bad[6]), .MANUAL_RESET_N(MANUAL_RESET_N),
        .PRODUCT1_TERM(PRODUCT1_TERM), .PRODUCT2_TERM(PRODUCT2_TERM),
        .TARGET_OUTPUT(TARGET_OUTPUT)
    );

    initial begin
        forever #4 REF_CLK = ~REF_CLK;
    end

    // ------------------------------------------------------------------
    // Reporting
    // ------------------------------------------------------------------
    task automatic report_and_stop();
        if (bad_count == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // ------------------------------------------------------------------
    // Bus master; called just after a rising edge
    // ------------------------------------------------------------------
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge REF_CLK);
            n++;
        end while (HREADYOUT !== 1'b1 && n < 64);
        if (HREADYOUT !== 1'b1) begin
            bad_count++;
            report_and_stop();
        end
    endtask

    task automatic ahb(input logic w, input logic [9:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        HSEL <= 1'b1;
        HADDR <= {22'h0, a};
        HTRANS <= 2'b10;
        HWRITE <= w;
        HSIZE <= seq_p2_pkg::HSIZE_WORD;
        wait_ready();
        HTRANS <= 2'b00;
        HSEL <= 1'b0;
        HWDATA <= w ? wd : 32'h0;
        wait_ready();
        rd = HRDATA;
    endtask

    task automatic wr(input int i, input logic [31:0] d);
        logic [31:0] r;
        ahb(1'b1, maddr[i], d, r);
        mreg[i] = d[7:0];
    endtask

    task automatic rd_chk(input int i);
        logic [31:0] r;
        ahb(1'b0, maddr[i], 32'h0, r);
        check("select register", r, {24'h0, mreg[i]});
    endtask

    // ------------------------------------------------------------------
    // Conditions; a set bit of bad means that condition is not good
    // ------------------------------------------------------------------
    task automatic apply(input logic [24:0] b);
        VOLT_PRIMARY_GOOD <= ~b[5:0];
        WATCHDOG_EXPIRED <= b[7:6];
        VOLT_SECONDARY_GOOD <= ~b[13:8];
        GENERAL_INPUT_ACTIVE <= b[17:14];
        prog_bad <= b[24:18];
        repeat (3) @(posedge REF_CLK);
    endtask

    // Model result: bit 1 target output, bit 0 product two
    function automatic logic [1:0] model(input logic [24:0] b);
        logic [24:0] sv;
        logic p2;
        sv = {mreg[3][1], mreg[2], mreg[1], mreg[0]};
        // Empty term counts as 0 so an unconfigured output is not held off
        p2 = (sv != 25'h0) && ((sv & b) == 25'h0);
        return {!(PRODUCT1_TERM || p2) || (mreg[4][2] && !MANUAL_RESET_N), p2};
    endfunction

    task automatic check_out(input logic [24:0] b);
        logic [1:0] m;
        logic [31:0] r;
        m = model(b);
        check("idle read data", HRDATA, 32'h0);
        check("product2", {31'h0, PRODUCT2_TERM}, {31'h0, m[0]});
        check("target", {31'h0, TARGET_OUTPUT}, {31'h0, m[1]});
        ahb(1'b0, seq_p2_pkg::ADDR_STATUS, 32'h0, r);
        check("status", r, {28'h0, mreg[4][2] && !MANUAL_RESET_N, PRODUCT1_TERM, m});
    endtask

    task automatic reset_model();
        for (int i = 0; i < 5; i++) begin
            mreg[i] = 8'h00;
        end
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        maddr = '{seq_p2_pkg::ADDR_P2_PRIMARY, seq_p2_pkg::ADDR_P2_SECONDARY,
                  seq_p2_pkg::ADDR_P2_OUTPUTS, seq_p2_pkg::ADDR_OUT8_SELECT,
                  seq_p2_pkg::ADDR_MANUAL_SELECT};
        reset_model();
        void'($urandom(61));
        repeat (12) @(posedge REF_CLK);
        RSTN <= 1'b1;
        repeat (3) @(posedge REF_CLK);
        check_out(25'h0);
        for (int i = 0; i < 5; i++) begin
            rd_chk(i);
        end
        // Unmapped place: write is dropped, read gives zero
        ahb(1'b1, 10'h074, 32'hffff_ffff, rdat);
        ahb(1'b0, 10'h074, 32'h0, rdat);
        check("unmapped read", rdat, 32'h0);
        check("response", {31'h0, HRESP}, {31'h0, seq_p2_pkg::HRESP_OKAY});
        for (int i = 0; i < 5; i++) begin
            wr(i, $urandom);
        end
        for (int i = 0; i < 5; i++) begin
            rd_chk(i);
        end
        // One condition at a time: selected one good with all others bad, then reversed
        wr(4, 32'h0);
        PRODUCT1_TERM <= 1'b0;
        for (int b = 0; b < 25; b++) begin
            s = 25'h1 << b;
            wr(0, {24'h0, s[7:0]});
            wr(1, {24'h0, s[15:8]});
            wr(2, {24'h0, s[23:16]});
            wr(3, {30'h0, s[24], 1'b0});
            apply(~s);
            check_out(~s);
            apply(s);
            check_out(s);
        end
        // Random selects, conditions, product 1 and manual reset
        for (int n = 0; n < 200; n++) begin
            for (int i = 0; i < 4; i++) begin
                wr(i, $urandom & $urandom);
            end
            wr(4, $urandom);
            rnd = $urandom;
            MANUAL_RESET_N <= rnd[0];
            PRODUCT1_TERM <= rnd[1] & rnd[2];
            bad = 25'($urandom & $urandom & $urandom);
            apply(bad);
            check_out(bad);
        end
        // Small-variant software: selects of absent inputs and outputs kept zero
        for (int n = 0; n < 20; n++) begin
            wr(0, $urandom & 32'hcf);
            wr(1, $urandom & 32'hcf);
            wr(2, $urandom & 32'hf3);
            wr(3, $urandom & 32'hfd);
            bad = 25'($urandom & $urandom);
            apply(bad);
            check_out(bad);
        end
        // Clock enable low freezes the outputs at their last value
        rdat = {30'h0, model(bad)};
        CLK_EN <= 1'b0;
        apply(~bad);
        check("frozen outputs", {30'h0, TARGET_OUTPUT, PRODUCT2_TERM}, rdat);
        CLK_EN <= 1'b1;
        apply(~bad);
        check_out(~bad);
        // Second reset in mid-run clears the selects again
        RSTN <= 1'b0;
        repeat (2) @(posedge REF_CLK);
        check("target in reset", {31'h0, TARGET_OUTPUT}, 32'h1);
        check("product2 in reset", {31'h0, PRODUCT2_TERM}, 32'h0);
        check("read data in reset", HRDATA, 32'h0);
        RSTN <= 1'b1;
        repeat (3) @(posedge REF_CLK);
        reset_model();
        for (int i = 0; i < 5; i++) begin
            rd_chk(i);
        end
        check_out(~bad);
        report_and_stop();
    end
endmodule

`default_nettype wire
